// ==== isr_status_top.sv ====
// Status reporting register bank: condition, event, mask and status byte
`timescale 1ns/1ps
module isr_status_top
  import isr_pkg::*;
#(
  parameter int W = REG_W
)
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // Operating state pins
  input  wire logic         constant_current,
  input  wire logic         constant_voltage,
  input  wire logic         list_running,
  input  wire logic         list_finished,
  input  wire logic         sample_done,
  input  wire logic         transient_done,
  input  wire logic         pulse_primed,
  input  wire logic         awaiting_trigger,
  // Questionable state pins
  input  wire logic         absorbing_load_energy,
  input  wire logic         current_error,
  input  wire logic         voltage_error,
  input  wire logic         follower_unit_error,
  input  wire logic         thermal_fault,
  input  wire logic         current_mode_fault,
  input  wire logic         voltage_mode_fault,
  // Query command port
  input  wire logic         cmd_valid,
  input  wire logic [3:0]   cmd_code,
  input  wire logic [15:0]  cmd_data,
  // Query answer
  output logic              rsp_valid,
  output logic [15:0]       rsp_data,
  output logic              rsp_error,
  // Status byte summary bits
  output logic [7:0]        status_byte
);
  logic [15:0] op_raw;
  logic [15:0] qu_raw;
  logic [15:0] operation_condition;
  logic [15:0] questionable_condition;
  logic [15:0] operation_enable_mask;
  logic [15:0] questionable_enable_mask;
  logic [15:0] operation_event_latch;
  logic [15:0] questionable_event_latch;
  logic [15:0] next_op_event;
  logic [15:0] next_qu_event;
  logic [15:0] op_rise;
  logic [15:0] qu_rise;
  logic [15:0] next_op_mask;
  logic [15:0] next_qu_mask;
  logic [15:0] next_rsp_data;
  logic        next_rsp_error;
  logic        op_read;
  logic        qu_read;

  if (W != 16)
  begin : g_chk
    $error("isr_status_top registers are fixed at 16 bits");
  end

  // Command match, used for the read strobe, mask write and preset decodes below
  function automatic logic cmd_is(input logic v, input logic [3:0] code,
                                  input logic [3:0] want);
    cmd_is = v && (code == want);
  endfunction

  // Place each pin at its register bit position; unused bits stay zero
  always_comb
  begin
    op_raw                        = '0;
    op_raw[OP_CONSTANT_CURRENT]   = constant_current;
    op_raw[OP_CONSTANT_VOLTAGE]   = constant_voltage;
    op_raw[OP_AWAITING_TRIGGER]   = awaiting_trigger;
    op_raw[OP_PULSE_PRIMED]       = pulse_primed;
    op_raw[OP_TRANSIENT_DONE]     = transient_done;
    op_raw[OP_LIST_RUNNING]       = list_running;
    op_raw[OP_LIST_FINISHED]      = list_finished;
    op_raw[OP_SAMPLE_DONE]        = sample_done;
  end

  // Mode faults pass independently, so both may show while output settles
  always_comb
  begin
    qu_raw                         = '0;
    qu_raw[QU_CURRENT_ERROR]       = current_error;
    qu_raw[QU_VOLTAGE_ERROR]       = voltage_error;
    qu_raw[QU_CURRENT_MODE_FAULT]  = current_mode_fault;
    qu_raw[QU_VOLTAGE_MODE_FAULT]  = voltage_mode_fault;
    qu_raw[QU_ABSORBING_ENERGY]    = absorbing_load_energy;
    qu_raw[QU_FOLLOWER_UNIT_ERROR] = follower_unit_error;
    qu_raw[QU_THERMAL_FAULT]       = thermal_fault;
  end

  // Live condition registers: pins cross in, nothing latched
  isr_pin_sync #(.W(16)) u_op_sync
  (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .pin_raw    (op_raw),
    .pin_stable (operation_condition)
  );

  isr_pin_sync #(.W(16)) u_qu_sync
  (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .pin_raw    (qu_raw),
    .pin_stable (questionable_condition)
  );

  // Clearing reads of the event registers
  assign op_read = cmd_is(cmd_valid, cmd_code, CMD_OP_EVENT_RD);
  assign qu_read = cmd_is(cmd_valid, cmd_code, CMD_QU_EVENT_RD);

  // Operation events latch on every used bit
  isr_event_latch #(.W(16), .LATCH_MASK(OP_USED_MASK)) u_op_event
  (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .cond       (operation_condition),
    .read_clear (op_read),
    .event_q    (operation_event_latch),
    .next_event (next_op_event),
    .rise       (op_rise)
  );

  // Questionable events latch on the current and voltage error bits only
  isr_event_latch #(.W(16), .LATCH_MASK(QU_LATCH_MASK)) u_qu_event
  (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .cond       (questionable_condition),
    .read_clear (qu_read),
    .event_q    (questionable_event_latch),
    .next_event (next_qu_event),
    .rise       (qu_rise)
  );

  // Mask writes keep all 16 bits; preset overrides both masks
  always_comb
  begin
    next_op_mask = operation_enable_mask;
    next_qu_mask = questionable_enable_mask;
    if (cmd_is(cmd_valid, cmd_code, CMD_OP_MASK_WR))
      next_op_mask = cmd_data;
    if (cmd_is(cmd_valid, cmd_code, CMD_QU_MASK_WR))
      next_qu_mask = cmd_data;
    if (cmd_is(cmd_valid, cmd_code, CMD_PRESET))
    begin
      next_op_mask = OP_MASK_PRESET;
      next_qu_mask = QU_MASK_PRESET;
    end
  end

  // Enable mask storage
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      operation_enable_mask    <= OP_MASK_RESET;
      questionable_enable_mask <= QU_MASK_RESET;
    end
    else
    begin
      operation_enable_mask    <= next_op_mask;
      questionable_enable_mask <= next_qu_mask;
    end
  end

  // Summaries use next values so the byte always matches the stored registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      status_byte <= 8'h00;
    else
    begin
      status_byte                  <= 8'h00;
      status_byte[SB_OPER_SUMMARY] <= |(next_op_event & next_op_mask);
      status_byte[SB_QUES_SUMMARY] <= |(next_qu_event & next_qu_mask);
    end
  end

  // Answer selection; event reads return the value before the clear
  always_comb
  begin
    next_rsp_data  = 16'h0000;
    next_rsp_error = 1'b0;
    unique case (cmd_code)
      CMD_OP_COND_RD:  next_rsp_data = operation_condition;
      CMD_OP_EVENT_RD: next_rsp_data = operation_event_latch;
      CMD_OP_MASK_RD:  next_rsp_data = operation_enable_mask;
      CMD_QU_COND_RD:  next_rsp_data = questionable_condition;
      CMD_QU_EVENT_RD: next_rsp_data = questionable_event_latch;
      CMD_QU_MASK_RD:  next_rsp_data = questionable_enable_mask;
      CMD_OP_MASK_WR,
      CMD_QU_MASK_WR,
      CMD_PRESET:      next_rsp_data = 16'h0000;
      default:         next_rsp_error = 1'b1;
    endcase
  end

  // Every command gets exactly one answer the following cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
      rsp_error <= 1'b0;
    end
    else
    begin
      rsp_valid <= cmd_valid;
      rsp_data  <= cmd_valid ? next_rsp_data : 16'h0000;
      rsp_error <= cmd_valid & next_rsp_error;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_op_summary_or : assert property (
    status_byte[SB_OPER_SUMMARY] == |(operation_event_latch & operation_enable_mask))
    else $error("operation summary differs from masked events");

  a_ques_summary_or : assert property (
    status_byte[SB_QUES_SUMMARY] == |(questionable_event_latch & questionable_enable_mask))
    else $error("questionable summary differs from masked events");

  a_op_read_clear : assert property (
    (op_read && op_rise == 16'h0000) |=> (operation_event_latch == 16'h0000)
                                         && (rsp_data == $past(operation_event_latch)))
    else $error("operation event read did not return and clear");

  a_ques_read_clear : assert property (
    (qu_read && qu_rise == 16'h0000) |=> (questionable_event_latch == 16'h0000)
                                         && (rsp_data == $past(questionable_event_latch)))
    else $error("questionable event read did not return and clear");

  a_ques_latch_only : assert property (
    (questionable_event_latch & ~QU_LATCH_MASK) == 16'h0000)
    else $error("questionable bit outside 13 and 12 latched");

  a_mode_no_latch : assert property (
    questionable_condition[QU_VOLTAGE_MODE_FAULT] |-> ##2
      !questionable_event_latch[QU_VOLTAGE_MODE_FAULT])
    else $error("mode fault reached questionable event register");

  a_op_layout : assert property (
    ((operation_condition | operation_event_latch) & ~OP_USED_MASK) == 16'h0000)
    else $error("operation unused bit set");

  a_event_rise_set : assert property (
    $rose(operation_condition[OP_CONSTANT_CURRENT])
      |=> operation_event_latch[OP_CONSTANT_CURRENT])
    else $error("constant current event not set the cycle after rise");

  a_set_beats_clear : assert property (
    (qu_read && qu_rise != 16'h0000) |=> ((questionable_event_latch & $past(qu_rise))
                                          == $past(qu_rise)))
    else $error("event coinciding with clear was lost");

  a_event_hold : assert property (
    (operation_event_latch[OP_LIST_RUNNING] && !op_read)
      |=> operation_event_latch[OP_LIST_RUNNING])
    else $error("operation event dropped without a read");

  a_preset_masks : assert property (
    cmd_is(cmd_valid, cmd_code, CMD_PRESET) |=> (operation_enable_mask == OP_MASK_PRESET)
      && (questionable_enable_mask == QU_MASK_PRESET))
    else $error("preset did not load both masks");

  a_mask_query : assert property (
    cmd_is(cmd_valid, cmd_code, CMD_OP_MASK_WR)
      ##1 cmd_is(cmd_valid, cmd_code, CMD_OP_MASK_RD) |=> (rsp_data == $past(cmd_data, 2)))
    else $error("operation mask query did not return written value");

  // --------------------------------------------------------------------------
  // Assertions on answers, masks, events and quiet bits
  // --------------------------------------------------------------------------

  a_op_set_wins : assert property (
    (op_read && op_rise != 16'h0000) |=> ((operation_event_latch & $past(op_rise))
                                         == $past(op_rise)))
    else $error("operation event coinciding with clear was lost");

  a_op_cond_answer : assert property (
    cmd_is(cmd_valid, cmd_code, CMD_OP_COND_RD) |=> (rsp_data == $past(operation_condition)))
    else $error("operation condition query returned a stale value");

  a_qu_cond_answer : assert property (
    cmd_is(cmd_valid, cmd_code, CMD_QU_COND_RD)
      |=> (rsp_data == $past(questionable_condition)))
    else $error("questionable condition query returned a stale value");

  a_op_mask_write : assert property (
    cmd_is(cmd_valid, cmd_code, CMD_OP_MASK_WR) |=> (operation_enable_mask == $past(cmd_data)))
    else $error("operation mask write not stored");

  a_op_mask_stable : assert property (
    !cmd_valid |=> $stable(operation_enable_mask))
    else $error("operation mask changed without a command");

  a_qu_rise_set : assert property (
    $rose(questionable_condition[QU_CURRENT_ERROR])
      |=> questionable_event_latch[QU_CURRENT_ERROR])
    else $error("current error event not set the cycle after rise");

  a_qu_event_hold : assert property (
    (questionable_event_latch[QU_VOLTAGE_ERROR] && !qu_read)
      |=> questionable_event_latch[QU_VOLTAGE_ERROR])
    else $error("questionable event dropped without a read");

  a_cmode_no_latch : assert property (
    questionable_condition[QU_CURRENT_MODE_FAULT] |-> ##2
      !questionable_event_latch[QU_CURRENT_MODE_FAULT])
    else $error("current mode fault reached questionable event register");

  a_op_rise_only : assert property (
    (!$rose(operation_condition[OP_LIST_RUNNING]) && !operation_event_latch[OP_LIST_RUNNING])
      |=> !operation_event_latch[OP_LIST_RUNNING])
    else $error("list running event set without a rise");

  a_qu_rise_only : assert property (
    (!$rose(questionable_condition[QU_VOLTAGE_ERROR])
      && !questionable_event_latch[QU_VOLTAGE_ERROR])
      |=> !questionable_event_latch[QU_VOLTAGE_ERROR])
    else $error("voltage error event set without a rise");

  a_status_unused : assert property (
    (status_byte & 8'h77) == 8'h00)
    else $error("status byte bit outside the summaries set");

  a_qu_layout : assert property (
    (questionable_condition & ~QU_USED_MASK) == 16'h0000)
    else $error("questionable unused bit set");

  c_preset : cover property (cmd_is(cmd_valid, cmd_code, CMD_PRESET));
  c_set_clear : cover property (op_read && op_rise != 16'h0000);
  c_both_modes : cover property (questionable_condition[QU_VOLTAGE_MODE_FAULT]
                                 && questionable_condition[QU_CURRENT_MODE_FAULT]);
  c_op_summary : cover property ($rose(status_byte[SB_OPER_SUMMARY]));
  c_mask_query : cover property (cmd_is(cmd_valid, cmd_code, CMD_OP_MASK_WR)
                                 ##1 cmd_is(cmd_valid, cmd_code, CMD_OP_MASK_RD));
endmodule

// ==== isr_pkg.sv ====
// Constants for the instrument status reporting block
// ----------------------------------------------------------------------------
// Overview of operation
// - Operation condition bit 10 flags constant current, bit 8 constant voltage.
// - Operation group: awaiting trigger bit 5, pulse primed 6, transient done 9.
// - Operation layout: list running 14, list finished 12, sample done 11; rest unused.
// - Operation condition follows live state unlatched; query returns current contents.
// - Operation event register is read-only and holds every event until read.
// - Reading operation events returns the value, then clears all bits except those rising in the read cycle.
// - Status byte bit 7 is OR of operation events gated by enable mask.
// - Operation enable mask query returns the last written value.
// - Preset loads operation mask with 8193 and questionable mask with 255.
// - Only questionable bits 13 and 12 latch events.
// - Mode fault bits 0 and 1 never reach the questionable event register.
// - Reading questionable events returns the latched value, then clears it.
// - Questionable: current error 13, voltage error 12, mode faults 1 and 0.
// - Questionable bit 14 flags the supply absorbing load energy.
// - Questionable: follower unit error bit 6, thermal fault bit 3; rest unused.
// - Questionable condition tracks live conditions unlatched, one meaning active.
// - Both mode fault bits may stand together while output settles.
// - Status byte bit 3 is OR of questionable events gated by enable mask.
// ----------------------------------------------------------------------------
package isr_pkg;
  localparam int REG_W = 16;

  // Operation group bit positions
  localparam int OP_AWAITING_TRIGGER = 5;
  localparam int OP_PULSE_PRIMED     = 6;
  localparam int OP_CONSTANT_VOLTAGE = 8;
  localparam int OP_TRANSIENT_DONE   = 9;
  localparam int OP_CONSTANT_CURRENT = 10;
  localparam int OP_SAMPLE_DONE      = 11;
  localparam int OP_LIST_FINISHED    = 12;
  localparam int OP_LIST_RUNNING     = 14;

  // Questionable group bit positions
  localparam int QU_VOLTAGE_MODE_FAULT  = 0;
  localparam int QU_CURRENT_MODE_FAULT  = 1;
  localparam int QU_THERMAL_FAULT       = 3;
  localparam int QU_FOLLOWER_UNIT_ERROR = 6;
  localparam int QU_VOLTAGE_ERROR       = 12;
  localparam int QU_CURRENT_ERROR       = 13;
  localparam int QU_ABSORBING_ENERGY    = 14;

  // Used and latching bit sets
  localparam logic [15:0] OP_USED_MASK    = 16'h5F60;
  localparam logic [15:0] QU_USED_MASK    = 16'h704B;
  localparam logic [15:0] QU_LATCH_MASK   = 16'h3000;

  // Preset and reset values of the enable masks
  localparam logic [15:0] OP_MASK_PRESET  = 16'h2001;
  localparam logic [15:0] QU_MASK_PRESET  = 16'h00FF;
  localparam logic [15:0] OP_MASK_RESET   = 16'h0000;
  localparam logic [15:0] QU_MASK_RESET   = 16'h0000;

  // Status byte summary positions
  localparam int SB_QUES_SUMMARY = 3;
  localparam int SB_OPER_SUMMARY = 7;

  // Command codes of the query port
  localparam logic [3:0] CMD_OP_COND_RD  = 4'h0;
  localparam logic [3:0] CMD_OP_EVENT_RD = 4'h1;
  localparam logic [3:0] CMD_OP_MASK_RD  = 4'h2;
  localparam logic [3:0] CMD_OP_MASK_WR  = 4'h3;
  localparam logic [3:0] CMD_QU_COND_RD  = 4'h4;
  localparam logic [3:0] CMD_QU_EVENT_RD = 4'h5;
  localparam logic [3:0] CMD_QU_MASK_RD  = 4'h6;
  localparam logic [3:0] CMD_QU_MASK_WR  = 4'h7;
  localparam logic [3:0] CMD_PRESET      = 4'h8;
endpackage

// ==== isr_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module isr_pin_sync
  import isr_pkg::*;
#(
  parameter int W = 16
)
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // Pins and filtered result
  input  wire logic [W-1:0] pin_raw,
  output logic      [W-1:0] pin_stable
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  if (W < 1)
  begin : g_chk
    $error("isr_pin_sync needs W of at least 1");
  end

  // Shift chain; stage1 feeds only stage2 to keep metastability contained
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= pin_raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A bit changes only once stages two and three agree; no latching beyond that
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      pin_stable <= '0;
    else
      pin_stable <= (stage3 & ~(stage2 ^ stage3)) | (pin_stable & (stage2 ^ stage3));
  end

  a_sync_accept : assert property (@(posedge clk_sys) disable iff (reset)
    (stage2 == stage3) |=> (pin_stable == $past(stage3)))
    else $error("stable pin value did not follow agreeing stages");
endmodule

// ==== isr_event_latch.sv ====
// Rising-edge event latch with clear-on-read, set beating clear
`timescale 1ns/1ps
module isr_event_latch
  import isr_pkg::*;
#(
  parameter int          W          = 16,
  parameter logic [15:0] LATCH_MASK = 16'hFFFF
)
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // Condition in, read strobe
  input  wire logic [W-1:0] cond,
  input  wire logic         read_clear,
  // Latched events and the value they take at the next edge
  output logic      [W-1:0] event_q,
  output logic      [W-1:0] next_event,
  output logic      [W-1:0] rise
);
  logic [W-1:0] cond_prev;

  if (W < 1 || W > 16)
  begin : g_chk
    $error("isr_event_latch supports W from 1 to 16");
  end

  // Only masked bits may ever latch
  assign rise       = cond & ~cond_prev & LATCH_MASK[W-1:0];
  assign next_event = (read_clear ? '0 : event_q) | rise;

  // Previous condition remembered to detect a rise
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      cond_prev <= '0;
    else
      cond_prev <= cond;
  end

  // Events hold until a read clears them
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      event_q <= '0;
    else
      event_q <= next_event;
  end
endmodule

// ==== instrument_status_reporting_bench.sv ====
// Self-checking bench for the instrument status reporting block
`timescale 1ns/1ps
module instrument_status_reporting_bench;
  import isr_pkg::*;

  // --------------------------------------------------------------------------
  // Stimulus, responses and bench model
  // --------------------------------------------------------------------------
  logic        clk_sys    = 1'b0;
  logic        reset      = 1'b1;
  logic [15:0] op_pin     = 16'h0000;
  logic [15:0] qu_pin     = 16'h0000;
  logic        cmd_valid  = 1'b0;
  logic [3:0]  cmd_code   = 4'h0;
  logic [15:0] cmd_data   = 16'h0000;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic        rsp_error;
  logic [7:0]  status_byte;
  logic [15:0] op_ev      = 16'h0000;
  logic [15:0] qu_ev      = 16'h0000;
  logic [15:0] op_mask    = OP_MASK_RESET;
  logic [15:0] qu_mask    = QU_MASK_RESET;
  logic [15:0] got;
  logic [15:0] acc;
  logic [31:0] r;
  logic [31:0] s;
  int          fail_count = 0;
  int          checks     = 0;

  // Free-running 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  // Pins are driven from the bench vectors at their register bit positions
  isr_status_top u_dut (
    .clk_sys               (clk_sys),
    .reset                 (reset),
    .constant_current      (op_pin[OP_CONSTANT_CURRENT]),
    .constant_voltage      (op_pin[OP_CONSTANT_VOLTAGE]),
    .list_running          (op_pin[OP_LIST_RUNNING]),
    .list_finished         (op_pin[OP_LIST_FINISHED]),
    .sample_done           (op_pin[OP_SAMPLE_DONE]),
    .transient_done        (op_pin[OP_TRANSIENT_DONE]),
    .pulse_primed          (op_pin[OP_PULSE_PRIMED]),
    .awaiting_trigger      (op_pin[OP_AWAITING_TRIGGER]),
    .absorbing_load_energy (qu_pin[QU_ABSORBING_ENERGY]),
    .current_error         (qu_pin[QU_CURRENT_ERROR]),
    .voltage_error         (qu_pin[QU_VOLTAGE_ERROR]),
    .follower_unit_error   (qu_pin[QU_FOLLOWER_UNIT_ERROR]),
    .thermal_fault         (qu_pin[QU_THERMAL_FAULT]),
    .current_mode_fault    (qu_pin[QU_CURRENT_MODE_FAULT]),
    .voltage_mode_fault    (qu_pin[QU_VOLTAGE_MODE_FAULT]),
    .cmd_valid             (cmd_valid),
    .cmd_code              (cmd_code),
    .cmd_data              (cmd_data),
    .rsp_valid             (rsp_valid),
    .rsp_data              (rsp_data),
    .rsp_error             (rsp_error),
    .status_byte           (status_byte)
  );

  // --------------------------------------------------------------------------
  // Compare, command and model tasks
  // --------------------------------------------------------------------------
  task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] seen);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic check_flag(input string name, input logic exp, input logic seen);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, seen);
    end
  endtask

  // Valid is left high so back-to-back commands never retoggle it in one step
  task automatic send(input logic [3:0] code, input logic [15:0] data);
    cmd_valid = 1'b1;
    cmd_code  = code;
    cmd_data  = data;
    @(posedge clk_sys);
    #1;
    got = rsp_data;
    check_flag("rsp_valid", 1'b1, rsp_valid);
    check_flag("rsp_error", code > CMD_PRESET, rsp_error);
    if (code == CMD_OP_MASK_WR || code == CMD_QU_MASK_WR || code >= CMD_PRESET)
      check_word("rsp_data", 16'h0000, got);
  endtask

  task automatic idle();
    cmd_valid = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  function automatic logic [7:0] exp_status();
    return {|(op_ev & op_mask), 3'b000, |(qu_ev & qu_mask), 3'b000};
  endfunction

  // Hold pins long enough for the synchroniser and the event latch to settle
  task automatic set_pins(input logic [15:0] op, input logic [15:0] qu);
    op_ev  = op_ev | (op & ~op_pin & OP_USED_MASK);
    qu_ev  = qu_ev | (qu & ~qu_pin & QU_LATCH_MASK);
    op_pin = op;
    qu_pin = qu;
    repeat (6) idle();
  endtask

  task automatic audit();
    send(CMD_OP_COND_RD, 16'h0000);
    check_word("op_cond", op_pin, got);
    send(CMD_QU_COND_RD, 16'h0000);
    check_word("qu_cond", qu_pin, got);
    send(CMD_OP_MASK_RD, 16'h0000);
    check_word("op_mask", op_mask, got);
    send(CMD_QU_MASK_RD, 16'h0000);
    check_word("qu_mask", qu_mask, got);
    idle();
    check_word("status", {8'h00, exp_status()}, {8'h00, status_byte});
  endtask

  task automatic read_events();
    send(CMD_OP_EVENT_RD, 16'h0000);
    check_word("op_event", op_ev, got);
    op_ev = 16'h0000;
    send(CMD_QU_EVENT_RD, 16'h0000);
    check_word("qu_event", qu_ev, got);
    qu_ev = 16'h0000;
    audit();
  endtask

  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hC7CA4204));
    repeat (2) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    read_events();
    // Unknown codes are refused and change nothing
    for (int c = 9; c < 16; c++)
      send(c[3:0], 16'hFFFF);
    audit();
    // Preset overrides masks written just before it
    send(CMD_OP_MASK_WR, 16'hFFFF);
    send(CMD_QU_MASK_WR, 16'hFFFF);
    send(CMD_PRESET, 16'h1234);
    op_mask = 16'h2001;
    qu_mask = 16'h00FF;
    audit();
    // Mode faults together never latch; only bits 13 and 12 do
    set_pins(16'h0000, 16'h0003);
    read_events();
    set_pins(16'h0000, QU_USED_MASK);
    set_pins(16'h0000, 16'h0000);
    qu_mask = 16'hFFFF;
    send(CMD_QU_MASK_WR, qu_mask);
    audit();
    read_events();
    read_events();
    // Random pins, masks and reads
    for (int i = 0; i < 150; i++)
    begin
      r = $urandom;
      s = $urandom;
      set_pins(r[15:0] & OP_USED_MASK, r[31:16] & QU_USED_MASK);
      if (s[0])
      begin
        op_mask = s[31:16];
        send(CMD_OP_MASK_WR, op_mask);
        send(CMD_OP_MASK_RD, 16'h0000);
        check_word("op_mask_rd", op_mask, got);
      end
      if (s[1])
      begin
        qu_mask = s[15:0];
        send(CMD_QU_MASK_WR, qu_mask);
      end
      audit();
      if (s[2])
        read_events();
    end
    // A rise landing on a clearing read must survive to a later read
    set_pins(16'h0000, 16'h0000);
    read_events();
    for (int g = 0; g < 2; g++)
    begin
      acc = 16'h0000;
      if (g == 0)
        op_pin = 16'h4400;
      else
        qu_pin = 16'h3000;
      for (int k = 0; k < 9; k++)
      begin
        send((g == 0) ? CMD_OP_EVENT_RD : CMD_QU_EVENT_RD, 16'h0000);
        acc = acc | got;
      end
      check_word("event_tail", 16'h0000, got);
      check_word("event_sum", (g == 0) ? 16'h4400 : 16'h3000, acc);
    end
    idle();
    audit();
    summarize();
  end

  // Watchdog well beyond the expected run of about 2500 cycles
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    fail_count++;
    summarize();
  end
endmodule
